// ---- inc/mcs_pkg.sv ----
// Constants, field layouts and carriers for the multichannel serial audio port.
// Assumes one core clock; link pins are sampled, never used as clocks.
package mcs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SAMPLE_W = 24;
	localparam int DIV_W = 16;
	localparam int POS_W = 7;
	localparam int DIR_TX = 0;
	localparam int DIR_RX = 1;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_TX_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] REG_RX_CFG = 8'h04;
	localparam logic [ADDR_W-1:0] REG_TX_DIV = 8'h08;
	localparam logic [ADDR_W-1:0] REG_RX_DIV = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_TX_DATA = 8'h10;
	localparam logic [ADDR_W-1:0] REG_RX_DATA = 8'h14;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
	// Frame lengths and sample widths in bit-clock cycles
	localparam logic [POS_W-1:0] LEN_32 = 7'h20;
	localparam logic [POS_W-1:0] LEN_48 = 7'h30;
	localparam logic [POS_W-1:0] LEN_64 = 7'h40;
	localparam logic [POS_W-1:0] WID_16 = 7'h10;
	localparam logic [POS_W-1:0] WID_18 = 7'h12;
	localparam logic [POS_W-1:0] WID_20 = 7'h14;
	localparam logic [POS_W-1:0] WID_24 = 7'h18;
	localparam logic [POS_W-1:0] LEFT_DELAY = 7'h01;
	localparam logic [POS_W-1:0] CODE_W = 7'h08;
	// Companding modes and constants
	localparam logic [1:0] COMP_NONE = 2'h0;
	localparam logic [1:0] COMP_MU = 2'h1;
	localparam logic [1:0] COMP_A = 2'h2;
	localparam logic [15:0] MU_BIAS = 16'h0084;
	localparam logic [15:0] MU_CLIP = 16'h1fde;
	localparam logic [15:0] MU_ADD = 16'h0021;
	localparam logic [15:0] A_SEG0 = 16'h0008;
	localparam logic [15:0] A_SEGN = 16'h0108;
	localparam logic [7:0] A_XOR = 8'h55;
	localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
	// Per-direction configuration word
	typedef struct packed {
		logic en;
		logic clk_ext;
		logic clk_pol;
		logic fs_pol;
		logic left_just;
		logic [1:0] len_sel;
		logic [1:0] wid_sel;
		logic [1:0] comp;
	} mcs_cfg_s;
	localparam mcs_cfg_s CFG_RESET = '0;
	// Sticky and level status bits
	typedef struct packed {
		logic rx_over;
		logic tx_under;
		logic rx_full;
		logic tx_full;
	} mcs_stat_s;
endpackage

// ---- rtl/mcs_port.sv ----
// Multichannel serial audio port: one tx and one rx path with their own framing.
// Assumes a plain register port and DMA that answers requests by register access.
//
// The register offsets and the plain strobed port were left to the implementer.
module mcs_port
	import mcs_pkg::*;
(
	input wire logic core_clk, // Core clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [ADDR_W-1:0] addr, // Register byte address
	input wire logic [DATA_W-1:0] wr_data, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [DATA_W-1:0] rd_data, // Read data, cycle after strobe
	input wire logic tx_bclk_i, // Tx bit clock pin in
	output logic tx_bclk_o, // Tx bit clock pin out
	output logic tx_bclk_oe, // Tx bit clock drive enable
	input wire logic tx_fs_i, // Tx frame sync pin in
	output logic tx_fs_o, // Tx frame sync pin out
	output logic tx_fs_oe, // Tx frame sync drive enable
	output logic tx_sd, // Tx serial data
	input wire logic rx_bclk_i, // Rx bit clock pin in
	output logic rx_bclk_o, // Rx bit clock pin out
	output logic rx_bclk_oe, // Rx bit clock drive enable
	input wire logic rx_fs_i, // Rx frame sync pin in
	output logic rx_fs_o, // Rx frame sync pin out
	output logic rx_fs_oe, // Rx frame sync drive enable
	input wire logic rx_sd, // Rx serial data
	output logic dma_tx_req, // Tx enabled and holding register empty
	output logic dma_rx_req // Rx holding register full
);
	// Frame length decode
	function automatic logic [POS_W-1:0] frame_len(input mcs_cfg_s c);
		unique case (c.len_sel)
			2'h0: frame_len = LEN_32;
			2'h1: frame_len = LEN_48;
			default: frame_len = LEN_64;
		endcase
	endfunction

	// Sample width decode
	function automatic logic [POS_W-1:0] sample_wid(input mcs_cfg_s c);
		unique case (c.wid_sel)
			2'h0: sample_wid = WID_16;
			2'h1: sample_wid = WID_18;
			2'h2: sample_wid = WID_20;
			default: sample_wid = WID_24;
		endcase
	endfunction

	// First data position of the slot
	function automatic logic [POS_W-1:0] start_pos(input mcs_cfg_s c);
		start_pos = c.left_just ? LEFT_DELAY : POS_W'(frame_len(c) - sample_wid(c));
	endfunction

	// True while a position carries sample data
	function automatic logic in_win(input logic [POS_W-1:0] p, input mcs_cfg_s c);
		in_win = (p >= start_pos(c)) && (p < POS_W'(start_pos(c) + sample_wid(c)));
	endfunction

	// Linear 16-bit to mu-law code
	function automatic logic [7:0] mu_enc(input logic [15:0] x);
		logic [15:0] m;
		logic [2:0] e;
		m = x[15] ? 16'(~x + 16'h0001) : x;
		m = m >> 2;
		if (m > MU_CLIP)
			m = MU_CLIP;
		m = m + MU_ADD;
		e = 3'h0;
		for (int i = 0; i < 8; i++)
			if (m[i + 5])
				e = 3'(i);
		mu_enc = ~{x[15], e, 4'(m >> (4'(e) + 4'h1))};
	endfunction

	// Mu-law code to linear 16-bit
	function automatic logic [15:0] mu_dec(input logic [7:0] code);
		logic [7:0] c;
		logic [15:0] m;
		c = ~code;
		m = ((16'(c[3:0]) << 3) + MU_BIAS) << c[6:4];
		m = m - MU_BIAS;
		mu_dec = c[7] ? 16'(~m + 16'h0001) : m;
	endfunction

	// Linear 16-bit to A-law code
	function automatic logic [7:0] a_enc(input logic [15:0] x);
		logic [15:0] m;
		logic [2:0] e;
		m = (x[15] ? ~x : x) >> 3;
		e = 3'h0;
		for (int i = 1; i < 8; i++)
			if (m[i + 4])
				e = 3'(i);
		a_enc = {~x[15], e, (e == 3'h0) ? 4'(m >> 1) : 4'(m >> e)} ^ A_XOR;
	endfunction

	// A-law code to linear 16-bit
	function automatic logic [15:0] a_dec(input logic [7:0] code);
		logic [7:0] c;
		logic [15:0] m;
		c = code ^ A_XOR;
		if (c[6:4] == 3'h0)
			m = (16'(c[3:0]) << 4) + A_SEG0;
		else
			m = ((16'(c[3:0]) << 4) + A_SEGN) << (c[6:4] - 3'h1);
		a_dec = c[7] ? m : 16'(~m + 16'h0001);
	endfunction

	mcs_cfg_s cfg [2];
	logic [DIV_W-1:0] div [2];
	logic [DIV_W-1:0] div_cnt [2];
	logic [POS_W-1:0] pos [2];
	logic [POS_W-1:0] next_pos [2];
	logic [1:0] bclk_pin, fs_pin, bclk_s1, bclk_s2, fs_s1, fs_s2;
	logic [1:0] int_clk, clk_prev, fs_prev, fs_out, tick;
	logic rx_sd_s1, rx_sd_s2;
	logic [SAMPLE_W-1:0] tx_hold, tx_sr, rx_sr, rx_hold, tx_load_val, rx_word;
	mcs_stat_s stat;
	logic tx_load, rx_done;

	assign bclk_pin = {rx_bclk_i, tx_bclk_i};
	assign fs_pin = {rx_fs_i, tx_fs_i};

	// Register writes: configuration and divider per direction
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cfg[DIR_TX] <= CFG_RESET;
			cfg[DIR_RX] <= CFG_RESET;
			div[DIR_TX] <= DIV_RESET;
			div[DIR_RX] <= DIV_RESET;
		end
		else if (wr_en)
		begin
			unique case (addr)
				REG_TX_CFG: cfg[DIR_TX] <= mcs_cfg_s'(wr_data[$bits(mcs_cfg_s)-1:0]);
				REG_RX_CFG: cfg[DIR_RX] <= mcs_cfg_s'(wr_data[$bits(mcs_cfg_s)-1:0]);
				REG_TX_DIV: div[DIR_TX] <= wr_data[DIV_W-1:0];
				REG_RX_DIV: div[DIR_RX] <= wr_data[DIV_W-1:0];
				default: ;
			endcase
		end
	end

	for (genvar d = 0; d < 2; d++)
	begin : g_dir
		logic lvl;
		logic fs_act;
		// Two-stage synchronisers for the link pins
		always_ff @(posedge core_clk)
		begin
			bclk_s1[d] <= bclk_pin[d];
			bclk_s2[d] <= bclk_s1[d];
			fs_s1[d] <= fs_pin[d];
			fs_s2[d] <= fs_s1[d];
		end

		always_ff @(posedge core_clk)
		begin
			if (rst || !cfg[d].en || cfg[d].clk_ext)
			begin
				div_cnt[d] <= DIV_RESET;
				int_clk[d] <= 1'b0;
			end
			else if (div_cnt[d] == div[d])
			begin
				div_cnt[d] <= DIV_RESET;
				int_clk[d] <= ~int_clk[d];
			end
			else
				div_cnt[d] <= div_cnt[d] + 16'h0001;
		end

		assign lvl = cfg[d].clk_ext ? bclk_s2[d] : int_clk[d];
		assign tick[d] = cfg[d].en && (cfg[d].clk_pol ? (!lvl && clk_prev[d]) : (lvl && !clk_prev[d]));
		assign fs_act = (fs_s2[d] == cfg[d].fs_pol);

		always_comb
		begin
			if (cfg[d].clk_ext && fs_act && !fs_prev[d])
				next_pos[d] = '0;
			else if (pos[d] >= POS_W'(frame_len(cfg[d]) - 7'h01))
				next_pos[d] = '0;
			else
				next_pos[d] = pos[d] + 7'h01;
		end

		// Bit position, edge history and generated sync
		always_ff @(posedge core_clk)
		begin
			if (rst)
			begin
				clk_prev[d] <= 1'b0;
				fs_prev[d] <= 1'b0;
				pos[d] <= '0;
				fs_out[d] <= 1'b0;
			end
			else
			begin
				clk_prev[d] <= lvl;
				// Park at all ones, past the last frame position, so enabling opens a whole frame
				if (!cfg[d].en)
					pos[d] <= '1;
				if (tick[d])
				begin
					fs_prev[d] <= fs_act;
					pos[d] <= next_pos[d];
					fs_out[d] <= (next_pos[d] == '0) ? cfg[d].fs_pol : !cfg[d].fs_pol;
				end
			end
		end
	end

	// Pin drivers; internal clock mode makes this end the clock master
	assign tx_bclk_o = int_clk[DIR_TX];
	assign rx_bclk_o = int_clk[DIR_RX];
	assign tx_fs_o = fs_out[DIR_TX];
	assign rx_fs_o = fs_out[DIR_RX];
	assign tx_bclk_oe = cfg[DIR_TX].en && !cfg[DIR_TX].clk_ext;
	assign rx_bclk_oe = cfg[DIR_RX].en && !cfg[DIR_RX].clk_ext;
	assign tx_fs_oe = tx_bclk_oe;
	assign rx_fs_oe = rx_bclk_oe;

	// load at slot start, left or right aligned
	assign tx_load = tick[DIR_TX] && (next_pos[DIR_TX] == start_pos(cfg[DIR_TX]));

	always_comb
	begin
		unique case (cfg[DIR_TX].comp)
			COMP_MU: tx_load_val = {mu_enc(tx_hold[15:0]), 16'h0000};
			COMP_A: tx_load_val = {a_enc(tx_hold[15:0]), 16'h0000};
			default: tx_load_val = SAMPLE_W'(tx_hold << (7'(SAMPLE_W) - sample_wid(cfg[DIR_TX])));
		endcase
		if (!stat.tx_full)
			tx_load_val = '0;
	end

	// transmit shifter, MSB first, zero outside slot
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tx_sd <= 1'b0;
			tx_sr <= '0;
		end
		else if (tick[DIR_TX])
		begin
			if (tx_load)
			begin
				tx_sd <= tx_load_val[SAMPLE_W-1];
				tx_sr <= tx_load_val << 1;
			end
			else if (in_win(next_pos[DIR_TX], cfg[DIR_TX]))
			begin
				tx_sd <= tx_sr[SAMPLE_W-1];
				tx_sr <= tx_sr << 1;
			end
			else
				tx_sd <= 1'b0;
		end
	end

	// Receive data synchroniser
	always_ff @(posedge core_clk)
	begin
		rx_sd_s1 <= rx_sd;
		rx_sd_s2 <= rx_sd_s1;
	end

	// completion at last bit of width
	assign rx_done = tick[DIR_RX] && in_win(next_pos[DIR_RX], cfg[DIR_RX]) &&
		(next_pos[DIR_RX] == POS_W'(start_pos(cfg[DIR_RX]) + sample_wid(cfg[DIR_RX]) - 7'h01));
	assign rx_word = SAMPLE_W'({rx_sr[SAMPLE_W-2:0], rx_sd_s2} &
		SAMPLE_W'((25'h1 << sample_wid(cfg[DIR_RX])) - 25'h1));

	always_ff @(posedge core_clk)
	begin
		if (rst)
			rx_sr <= '0;
		else if (tick[DIR_RX] && in_win(next_pos[DIR_RX], cfg[DIR_RX]))
			rx_sr <= {rx_sr[SAMPLE_W-2:0], rx_sd_s2};
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			rx_hold <= '0;
		else if (rx_done)
		begin
			unique case (cfg[DIR_RX].comp)
				COMP_MU: rx_hold <= SAMPLE_W'(signed'(mu_dec(8'(rx_word >>
					(sample_wid(cfg[DIR_RX]) - CODE_W)))));
				COMP_A: rx_hold <= SAMPLE_W'(signed'(a_dec(8'(rx_word >>
					(sample_wid(cfg[DIR_RX]) - CODE_W)))));
				default: rx_hold <= rx_word;
			endcase
		end
	end

	// Tx holding register, written by software or DMA
	always_ff @(posedge core_clk)
	begin
		if (rst)
			tx_hold <= '0;
		else if (wr_en && addr == REG_TX_DATA)
			tx_hold <= wr_data[SAMPLE_W-1:0];
	end

	// holding flags; a new event beats a clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
			stat <= '0;
		else
		begin
			if (wr_en && addr == REG_TX_DATA)
				stat.tx_full <= 1'b1;
			else if (tx_load)
				stat.tx_full <= 1'b0;
			if (rx_done)
				stat.rx_full <= 1'b1;
			else if (rd_en && addr == REG_RX_DATA)
				stat.rx_full <= 1'b0;
			if (tx_load && !stat.tx_full)
				stat.tx_under <= 1'b1;
			else if (wr_en && addr == REG_STATUS && wr_data[2])
				stat.tx_under <= 1'b0;
			if (rx_done && stat.rx_full && !(rd_en && addr == REG_RX_DATA))
				stat.rx_over <= 1'b1;
			else if (wr_en && addr == REG_STATUS && wr_data[3])
				stat.rx_over <= 1'b0;
		end
	end

	assign dma_tx_req = cfg[DIR_TX].en && !stat.tx_full;
	assign dma_rx_req = stat.rx_full;

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge core_clk)
	begin
		if (rst || !rd_en)
			rd_data <= '0;
		else
		begin
			unique case (addr)
				REG_TX_CFG: rd_data <= DATA_W'(cfg[DIR_TX]);
				REG_RX_CFG: rd_data <= DATA_W'(cfg[DIR_RX]);
				REG_TX_DIV: rd_data <= DATA_W'(div[DIR_TX]);
				REG_RX_DIV: rd_data <= DATA_W'(div[DIR_RX]);
				REG_TX_DATA: rd_data <= DATA_W'(tx_hold);
				REG_RX_DATA: rd_data <= DATA_W'(rx_hold);
				REG_STATUS: rd_data <= DATA_W'(stat);
				default: rd_data <= '0;
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	frame_wrap_a: assert property (
		tick[DIR_TX] && !cfg[DIR_TX].clk_ext && pos[DIR_TX] == frame_len(cfg[DIR_TX]) - 7'h01
		|=> pos[DIR_TX] == '0)
		else $error("tx frame did not wrap at frame length");
	sync_level_a: assert property (
		tick[DIR_RX] && next_pos[DIR_RX] == '0 |=> rx_fs_o == cfg[DIR_RX].fs_pol)
		else $error("rx sync not active at frame start");
	left_start_a: assert property (
		tx_load && cfg[DIR_TX].left_just |-> next_pos[DIR_TX] == LEFT_DELAY)
		else $error("left format load not one cycle after sync");
	right_end_a: assert property (
		rx_done && !cfg[DIR_RX].left_just |-> next_pos[DIR_RX] == frame_len(cfg[DIR_RX]) - 7'h01)
		else $error("right format sample not at slot end");
	msb_first_a: assert property (
		tx_load |=> tx_sd == $past(tx_load_val[SAMPLE_W-1]))
		else $error("first transmitted bit is not the sample MSB");
	idle_zero_a: assert property (
		tick[DIR_TX] && !tx_load && !in_win(next_pos[DIR_TX], cfg[DIR_TX]) |=> !tx_sd)
		else $error("data driven outside sample slot");
	dma_rx_a: assert property (
		rx_done |=> dma_rx_req ##1 (dma_rx_req || $past(rd_en && addr == REG_RX_DATA)))
		else $error("rx request missing after sample");
	dma_tx_a: assert property (
		wr_en && addr == REG_TX_DATA |=> !dma_tx_req)
		else $error("tx request stays after data write");
	compand_a: assert property (
		tx_load && (cfg[DIR_TX].comp == COMP_MU || cfg[DIR_TX].comp == COMP_A)
		|=> tx_sr[15:0] == '0)
		else $error("companded slot carries low bits");
	int_clk_a: assert property (
		cfg[DIR_TX].en && !cfg[DIR_TX].clk_ext && $changed(int_clk[DIR_TX]) && !$past(rst)
		&& $stable(div[DIR_TX]) |-> $past(div_cnt[DIR_TX]) == div[DIR_TX])
		else $error("internal clock toggled off divider count");

	cov_tx_frame_c: cover property (tx_load && stat.tx_full);
	cov_rx_mu_c: cover property (rx_done && cfg[DIR_RX].comp == COMP_MU);
	cov_rx_over_c: cover property ($rose(stat.rx_over));
	cov_ext_sync_c: cover property (tick[DIR_RX] && cfg[DIR_RX].clk_ext && next_pos[DIR_RX] == '0);
endmodule

// ---- testbench/mcs_codec_model.sv ----
// Behavioural audio codec on the serial port's link pins.
// Assumes the port masters the tx clock and sync; the model masters rx.
module mcs_codec_model
	import mcs_pkg::*;
(
	input wire logic tx_bclk, // Tx bit clock on the wire
	input wire logic tx_fs, // Tx frame sync on the wire
	input wire logic tx_sd, // Tx serial data
	input wire logic clk_pol, // Port active edge select
	input wire logic fs_pol, // Sync polarity select
	output logic rx_bclk, // Rx bit clock to port
	output logic rx_fs, // Rx frame sync to port
	output logic rx_sd // Rx serial data to port
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] cur = '0;
	int pos = -1;
	logic [63:0] txq[$];
	// Idle rx pins before the first frame
	initial
	begin
		rx_bclk = 1'b0;
		rx_fs = 1'b1;
		rx_sd = 1'b0;
	end
	// sync opens position 0, MSB first
	// whole frames of up to 64 bits kept
	always @(tx_bclk)
		if (tx_bclk === clk_pol)
		begin
			if (tx_fs === fs_pol)
			begin
				if (pos >= 0)
					txq.push_back(cur);
				cur = '0;
				pos = 0;
			end
			else if (pos >= 0)
				pos++;
			if (pos >= 0 && pos < 64)
				cur[63-pos] = tx_sd;
		end
	// external clock, runs only within a frame
	task automatic send_frame(input logic [63:0] bits, input int len);
		for (int p = 0; p < len; p++)
		begin
			rx_fs = (p == 0) ? fs_pol : ~fs_pol;
			rx_sd = bits[63-p];
			#400 rx_bclk = ~clk_pol;
			#400 rx_bclk = clk_pol;
		end
		// Released data line shows the inverse of its last bit
		rx_fs = ~fs_pol;
		rx_sd = ~rx_sd;
	endtask
endmodule

// ---- testbench/mcs_port_tb_top.sv ----
// Self-checking bench: registers, tx and rx framing, companding, DMA requests.
// Assumes the codec model on the link pins and a 10 MHz core clock.
module mcs_port_tb_top
	import mcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [ADDR_W-1:0] RMAP [7] = '{REG_TX_CFG, REG_RX_CFG, REG_TX_DIV,
		REG_RX_DIV, REG_STATUS, 8'h1c, 8'h11};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wr_data = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DATA_W-1:0] rd_data;
	logic tx_bclk_o, tx_bclk_oe, tx_fs_o, tx_fs_oe, tx_sd;
	logic rx_bclk_o, rx_bclk_oe, rx_fs_o, rx_fs_oe, dma_tx_req, dma_rx_req;
	logic p_bclk, p_fs, p_sd;
	logic pcp = 1'b0;
	logic pfp = 1'b0;
	logic [31:0] seed = 32'h0001_0f9f;
	int fail_count = 0;
	int tests_run = 0;
	// Wire levels from the port's drive enables; released rx pins take the codec model
	wire logic tx_bclk_w = tx_bclk_oe ? tx_bclk_o : 1'b0;
	wire logic tx_fs_w = tx_fs_oe ? tx_fs_o : 1'b0;
	wire logic rx_bclk_w = rx_bclk_oe ? rx_bclk_o : p_bclk;
	wire logic rx_fs_w = rx_fs_oe ? rx_fs_o : p_fs;
	mcs_port DUT (
		.core_clk(core_clk),
		.rst(rst),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.tx_bclk_i(tx_bclk_w),
		.tx_bclk_o(tx_bclk_o),
		.tx_bclk_oe(tx_bclk_oe),
		.tx_fs_i(tx_fs_w),
		.tx_fs_o(tx_fs_o),
		.tx_fs_oe(tx_fs_oe),
		.tx_sd(tx_sd),
		.rx_bclk_i(rx_bclk_w),
		.rx_bclk_o(rx_bclk_o),
		.rx_bclk_oe(rx_bclk_oe),
		.rx_fs_i(rx_fs_w),
		.rx_fs_o(rx_fs_o),
		.rx_fs_oe(rx_fs_oe),
		.rx_sd(p_sd),
		.dma_tx_req(dma_tx_req),
		.dma_rx_req(dma_rx_req)
	);
	mcs_codec_model codec (
		.tx_bclk(tx_bclk_w),
		.tx_fs(tx_fs_w),
		.tx_sd(tx_sd),
		.clk_pol(pcp),
		.fs_pol(pfp),
		.rx_bclk(p_bclk),
		.rx_fs(p_fs),
		.rx_sd(p_sd)
	);
	// Core clock, 100 ns period
	always #50 core_clk = ~core_clk;
	// Xorshift stimulus source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Frame bits with position 0 in bit 63, sample MSB first
	function automatic logic [63:0] fexp(logic [23:0] s, int len, int w, logic lj);
		logic [63:0] f;
		int b;
		f = '0;
		b = lj ? 1 : len - w;
		for (int i = 0; i < w; i++)
			f[63-b-i] = s[w-1-i];
		return f;
	endfunction
	function automatic int flen(logic [1:0] ls);
		return ls == 2'h0 ? 32 : (ls == 2'h1 ? 48 : 64);
	endfunction
	function automatic int fwid(logic [1:0] ws);
		return ws == 2'h3 ? 24 : 16 + 2 * ws;
	endfunction
	// Compare and count
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		@(posedge core_clk);
	endtask
	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		@(posedge core_clk);
		d = rd_data;
	endtask
	task automatic summarize();
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Program tx, preload one sample, feed two more on request, compare three captured frames
	task automatic tx_case(logic [1:0] ls, ws, logic lj, cp, fp, logic [1:0] c);
		int len, w, i;
		logic [23:0] s[3];
		logic [23:0] es;
		logic [DATA_W-1:0] d;
		len = flen(ls);
		w = c != 2'h0 ? 8 : fwid(ws);
		es = c == 2'h1 ? 24'hff : 24'hd5;
		for (int k = 0; k < 3; k++)
			s[k] = c != 2'h0 ? 24'h0 : 24'(rnd() | 32'h1);
		pcp <= cp;
		pfp <= fp;
		codec.txq.delete();
		wr(REG_TX_DIV, 32'h3);
		wr(REG_TX_DATA, 32'(s[0]));
		rd(REG_STATUS, d);
		chk("tx full", 1'b1, d[0]);
		wr(REG_TX_CFG, {21'h0, 2'b10, cp, fp, lj, ls, ws, c});
		chk("tx bclk oe", 1'b1, tx_bclk_oe);
		for (int k = 1; k < 3; k++)
		begin
			for (int t = 0; t < 1200 && dma_tx_req !== 1'b1; t++)
				@(posedge core_clk);
			chk("tx dma req", 1'b1, dma_tx_req);
			wr(REG_TX_DATA, 32'(s[k]));
		end
		for (int t = 0; t < 5000 && codec.txq.size() < 6; t++)
			@(posedge core_clk);
		i = 0;
		while (i < 3 && codec.txq[i] === 64'h0)
			i++;
		for (int k = 0; k < 3; k++)
			chk("tx frame", fexp(c != 2'h0 ? es : s[k], len, w, lj), codec.txq[i+k]);
		wr(REG_TX_CFG, '0);
	endtask
	// Codec sends one rx frame with junk outside the slot, sample fetched on request
	task automatic rx_case(logic [1:0] ls, ws, logic lj, logic [1:0] c);
		int len, w, n;
		logic [23:0] s, e;
		logic [63:0] m;
		logic [DATA_W-1:0] d;
		len = flen(ls);
		w = fwid(ws);
		n = c != 2'h0 ? 8 : w;
		s = c == 2'h1 ? 24'hff : (c == 2'h2 ? 24'hd5 : 24'(rnd()));
		e = c == 2'h2 ? 24'h8 : (c == 2'h1 ? 24'h0 : s);
		m = fexp(24'hffffff, len, n, lj);
		pcp <= 1'b0;
		pfp <= 1'b0;
		wr(REG_RX_CFG, {21'h0, 2'b11, 2'b00, lj, ls, ws, c});
		chk("rx bclk oe", 1'b0, rx_bclk_oe);
		#37;
		codec.send_frame(fexp(s, len, n, lj) | (~m & {rnd(), rnd()}), len);
		@(posedge core_clk);
		for (int t = 0; t < 200 && dma_rx_req !== 1'b1; t++)
			@(posedge core_clk);
		chk("rx dma req", 1'b1, dma_rx_req);
		rd(REG_RX_DATA, d);
		chk("rx sample", {8'h0, e} & ((32'h1 << w) - 1), d & ((32'h1 << w) - 1));
		wr(REG_RX_CFG, '0);
	endtask
	// Watchdog against a hang
	initial
	begin
		repeat (60000) @(posedge core_clk);
		fail_count++;
		summarize();
	end
	// Main sequence
	initial
	begin
		logic [DATA_W-1:0] d, v;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		foreach (RMAP[i])
		begin
			rd(RMAP[i], d);
			chk("reset reg", '0, d);
		end
		v = rnd();
		wr(REG_TX_DIV, v);
		wr(REG_RX_CFG, 32'hffff_fbff);
		wr(8'h1c, v);
		rd(REG_TX_DIV, d);
		chk("tx div", {16'h0, v[15:0]}, d);
		rd(REG_RX_DIV, d);
		chk("rx div", '0, d);
		rd(REG_RX_CFG, d);
		chk("rx cfg", 32'h3ff, d);
		rd(REG_TX_CFG, d);
		chk("tx cfg", '0, d);
		rd(8'h1c, d);
		chk("hole", '0, d);
		wr(REG_RX_CFG, '0);
		tx_case(2'h0, 2'h3, 1'b1, 1'b0, 1'b0, 2'h0);
		tx_case(2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 2'h0);
		tx_case(2'h1, 2'h3, 1'b0, 1'b0, 1'b1, 2'h0);
		tx_case(2'h2, 2'h1, 1'b0, 1'b0, 1'b0, 2'h0);
		tx_case(2'h2, 2'h2, 1'b1, 1'b1, 1'b1, 2'h0);
		tx_case(2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 2'h1);
		tx_case(2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 2'h2);
		rx_case(2'h0, 2'h3, 1'b1, 2'h0);
		rx_case(2'h2, 2'h0, 1'b0, 2'h0);
		rx_case(2'h1, 2'h2, 1'b0, 2'h0);
		rx_case(2'h0, 2'h0, 1'b1, 2'h1);
		rx_case(2'h0, 2'h0, 1'b1, 2'h2);
		summarize();
	end
endmodule
